// [logic/mfp_pkg.sv]
package mfp_pkg;

	// ==========================================================
	// Frame control field layout
	localparam int FCF_W          = 16;
	localparam int FT_LSB         = 0;
	localparam int FT_MSB         = 2;
	localparam int SEC_BIT        = 3;
	localparam int PEND_BIT       = 4;
	localparam int ACKREQ_BIT     = 5;
	localparam int PANC_BIT       = 6;
	localparam int DMODE_LSB      = 10;
	localparam int DMODE_MSB      = 11;
	localparam int VER_LSB        = 12;
	localparam int VER_MSB        = 13;
	localparam int SMODE_LSB      = 14;
	localparam int SMODE_MSB      = 15;

	// ==========================================================
	// Frame types
	localparam logic [2:0] FT_BEACON  = 3'h0;
	localparam logic [2:0] FT_DATA    = 3'h1;
	localparam logic [2:0] FT_ACK     = 3'h2;
	localparam logic [2:0] FT_CMD     = 3'h3;
	localparam logic [2:0] FT_MAX_STD = 3'h3;

	// ==========================================================
	// Addressing modes and versions
	localparam logic [1:0] AM_NONE  = 2'h0;
	localparam logic [1:0] AM_RSV   = 2'h1;
	localparam logic [1:0] AM_SHORT = 2'h2;
	localparam logic [1:0] AM_EXT   = 2'h3;
	localparam logic [1:0] VER_2003 = 2'h0;
	localparam logic [1:0] VER_2006 = 2'h1;

	// Octet counts of address fields
	localparam logic [3:0] LEN_PAN   = 4'h2;
	localparam logic [3:0] LEN_SHORT = 4'h2;
	localparam logic [3:0] LEN_EXT   = 4'h8;

	// Command identifier of a data request
	localparam logic [7:0] CMD_DATA_REQ = 8'h04;
	localparam logic [15:0] BCAST_SHORT = 16'hffff;

	// Acknowledgment frame: type ack, everything else zero but the pending bit
	localparam logic [15:0] ACK_FCF_BASE = 16'h0002;
	localparam logic [7:0]  ACK_PHR      = 8'h05;
	localparam logic [15:0] CRC_INIT     = 16'h0000;
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ        = 50;
	localparam int ACK_DEADLINE_US = 192;
	localparam int ACK_DEADLINE_CYC = ACK_DEADLINE_US * CLK_MHZ;
	localparam int TURN_US         = 12;
	localparam int TURN_CYC        = TURN_US * CLK_MHZ;

	// Ack version filter selections
	localparam logic [1:0] AVF_ANY    = 2'h0;
	localparam logic [1:0] AVF_LE1    = 2'h1;
	localparam logic [1:0] AVF_LE2    = 2'h2;
	localparam logic [1:0] AVF_NONE   = 2'h3;

	typedef enum logic [2:0] {
		MFP_IDLE = 3'b000,
		MFP_FCF  = 3'b001,
		MFP_SEQ  = 3'b010,
		MFP_ADDR = 3'b011,
		MFP_BODY = 3'b100
	} mfp_state_t;

	typedef enum logic [2:0] {
		ACK_IDLE = 3'b000,
		ACK_WAIT = 3'b001,
		ACK_SEND = 3'b010,
		ACK_DONE = 3'b011
	} mfp_ack_state_t;

endpackage : mfp_pkg

// [logic/mfp_crc16.sv]
`timescale 1ns/1ns
module mfp_crc16 (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Control
	input  wire logic        clear,
	input  wire logic        step,
	input  wire logic [7:0]  octet,
	// Result
	output logic      [15:0] crc
);

	function automatic logic [15:0] crc_octet(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ mfp_pkg::CRC_POLY_REV;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction : crc_octet

	// LSB-first ITU CRC as used on air
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			crc <= 16'h0000;
		end else if (clear) begin
			crc <= mfp_pkg::CRC_INIT;
		end else if (step) begin
			crc <= crc_octet(crc, octet);
		end
	end

endmodule : mfp_crc16

// [logic/mfp_frame_parser.sv]
`timescale 1ns/1ns
module mfp_frame_parser (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Configuration from the processor
	input  wire logic        auto_ack_receive_mode,
	input  wire logic        auto_retry_transmit_mode,
	input  wire logic        upload_reserved_frame_types,
	input  wire logic        ack_pending_flag_value,
	input  wire logic [1:0]  ack_version_filter_select,
	input  wire logic [15:0] own_pan_id,
	input  wire logic [15:0] own_short_addr,
	input  wire logic [63:0] own_ext_addr,
	// Received MPDU octets, PHR already stripped
	input  wire logic        rx_start,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_end,
	input  wire logic        rx_fcs_ok,
	// Transmit side frame control
	input  wire logic        tx_done,
	input  wire logic [15:0] tx_fcf,
	output logic             tx_wait_ack,
	output logic             tx_finish,
	// Parsed fields
	output logic [2:0]       frame_type,
	output logic             sec_enabled,
	output logic             ack_request,
	output logic             intra_pan,
	output logic [1:0]       dst_mode,
	output logic [1:0]       src_mode,
	output logic [1:0]       frame_version,
	output logic [7:0]       seq_num,
	output logic             secured_2006,
	output logic             secured_2003,
	output logic             fields_valid,
	// Filter results
	output logic             addr_match,
	output logic             frame_accept,
	// Ack frame octets out to the transmitter
	input  wire logic        ack_ready,
	output logic             ack_valid,
	output logic [7:0]       ack_data,
	output logic             ack_last,
	output logic             ack_late
);

	// ==========================================================
	// Parse state
	mfp_pkg::mfp_state_t st_r;
	logic [15:0]         fcf_r;
	logic [3:0]          cnt_r;
	logic [3:0]          fld_r;
	logic [3:0]          dst_len_r;
	logic [3:0]          src_len_r;
	logic                dst_phase_r;
	logic                dst_done_r;
	logic [63:0]         sh_r;
	logic                pan_ok_r;
	logic                dst_ok_r;
	logic                bcast_r;
	logic                cmd_seen_r;
	logic                data_req_r;

	function automatic logic [3:0] addr_len(input logic [1:0] m);
		case (m)
			mfp_pkg::AM_SHORT: addr_len = mfp_pkg::LEN_SHORT;
			mfp_pkg::AM_EXT:   addr_len = mfp_pkg::LEN_EXT;
			default:           addr_len = 4'h0;
		endcase
	endfunction : addr_len

	function automatic logic mode_present(input logic [1:0] m);
		mode_present = (m == mfp_pkg::AM_SHORT) || (m == mfp_pkg::AM_EXT);
	endfunction : mode_present

	// Field views of the captured frame control
	assign frame_type    = fcf_r[mfp_pkg::FT_MSB:mfp_pkg::FT_LSB];
	assign sec_enabled   = fcf_r[mfp_pkg::SEC_BIT];
	assign ack_request   = fcf_r[mfp_pkg::ACKREQ_BIT];
	assign intra_pan     = fcf_r[mfp_pkg::PANC_BIT];
	assign dst_mode      = fcf_r[mfp_pkg::DMODE_MSB:mfp_pkg::DMODE_LSB];
	assign src_mode      = fcf_r[mfp_pkg::SMODE_MSB:mfp_pkg::SMODE_LSB];
	assign frame_version = fcf_r[mfp_pkg::VER_MSB:mfp_pkg::VER_LSB];
	assign secured_2006  = sec_enabled && frame_version == mfp_pkg::VER_2006;
	assign secured_2003  = sec_enabled && frame_version == mfp_pkg::VER_2003;

	logic src_pan_len_zero;
	assign src_pan_len_zero = intra_pan && mode_present(dst_mode);

	// ==========================================================
	// Header walk: FCF, sequence, destination then source
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r        <= mfp_pkg::MFP_IDLE;
			fcf_r       <= 16'h0000;
			cnt_r       <= 4'h0;
			fld_r       <= 4'h0;
			dst_len_r   <= 4'h0;
			src_len_r   <= 4'h0;
			dst_phase_r <= 1'b0;
			dst_done_r  <= 1'b0;
			seq_num     <= 8'h00;
			fields_valid <= 1'b0;
		end else if (rx_start) begin
			st_r        <= mfp_pkg::MFP_FCF;
			cnt_r       <= 4'h0;
			fields_valid <= 1'b0;
			dst_done_r  <= 1'b0;
		end else if (rx_valid) begin
			case (st_r)
				mfp_pkg::MFP_FCF: begin
					// Octet 0 holds bits 7:0; bits 7..9 kept but never used
					if (cnt_r == 4'h0) begin
						fcf_r[7:0] <= rx_data;
						cnt_r      <= 4'h1;
					end else begin
						fcf_r[15:8] <= rx_data;
						st_r        <= mfp_pkg::MFP_SEQ;
					end
				end
				mfp_pkg::MFP_SEQ: begin
					seq_num      <= rx_data;
					fields_valid <= 1'b1;
					cnt_r        <= 4'h0;
					dst_phase_r  <= mode_present(dst_mode);
					fld_r        <= mode_present(dst_mode) ? mfp_pkg::LEN_PAN
						: (src_pan_len_zero ? 4'h0 : mfp_pkg::LEN_PAN);
					dst_len_r    <= addr_len(dst_mode);
					src_len_r    <= addr_len(src_mode);
					st_r         <= (mode_present(dst_mode) || mode_present(src_mode))
						? mfp_pkg::MFP_ADDR : mfp_pkg::MFP_BODY;
				end
				mfp_pkg::MFP_ADDR: begin
					// cnt_r counts fld_r PAN octets, then address octets
					if (cnt_r + 4'h1 == fld_r + (dst_phase_r ? dst_len_r : src_len_r)) begin
						cnt_r <= 4'h0;
						if (dst_phase_r && mode_present(src_mode)) begin
							dst_phase_r <= 1'b0;
							dst_done_r  <= 1'b1;
							fld_r       <= src_pan_len_zero ? 4'h0 : mfp_pkg::LEN_PAN;
						end else begin
							dst_done_r <= dst_phase_r | dst_done_r;
							st_r       <= mfp_pkg::MFP_BODY;
						end
					end else begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				mfp_pkg::MFP_BODY: begin
					st_r <= mfp_pkg::MFP_BODY;
				end
				default: st_r <= mfp_pkg::MFP_IDLE;
			endcase
		end else if (rx_end) begin
			st_r <= mfp_pkg::MFP_IDLE;
		end
	end

	// ==========================================================
	// Destination compare: shift octets, compare on last one
	logic in_dst;
	logic dst_pan_last;
	logic dst_addr_last;
	assign in_dst        = rx_valid && st_r == mfp_pkg::MFP_ADDR && dst_phase_r;
	assign dst_pan_last  = in_dst && cnt_r == mfp_pkg::LEN_PAN - 4'h1;
	assign dst_addr_last = in_dst && cnt_r + 4'h1 == mfp_pkg::LEN_PAN + dst_len_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sh_r     <= 64'h0;
			pan_ok_r <= 1'b0;
			dst_ok_r <= 1'b0;
			bcast_r  <= 1'b0;
		end else if (rx_start) begin
			pan_ok_r <= 1'b0;
			dst_ok_r <= 1'b0;
			bcast_r  <= 1'b0;
		end else if (in_dst) begin
			sh_r <= {rx_data, sh_r[63:8]};
			if (dst_pan_last) begin
				pan_ok_r <= {rx_data, sh_r[63:56]} == own_pan_id
					|| {rx_data, sh_r[63:56]} == mfp_pkg::BCAST_SHORT;
			end
			if (dst_addr_last) begin
				if (dst_mode == mfp_pkg::AM_SHORT) begin
					bcast_r  <= {rx_data, sh_r[63:56]} == mfp_pkg::BCAST_SHORT;
					dst_ok_r <= {rx_data, sh_r[63:56]} == own_short_addr
						|| {rx_data, sh_r[63:56]} == mfp_pkg::BCAST_SHORT;
				end else begin
					dst_ok_r <= {rx_data, sh_r[63:8]} == own_ext_addr;
				end
			end
		end
	end

	// Data-request detection: first payload octet of a command frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_seen_r <= 1'b0;
			data_req_r <= 1'b0;
		end else if (rx_start) begin
			cmd_seen_r <= 1'b0;
			data_req_r <= 1'b0;
		end else if (rx_valid && st_r == mfp_pkg::MFP_BODY && !cmd_seen_r) begin
			cmd_seen_r <= 1'b1;
			data_req_r <= frame_type == mfp_pkg::FT_CMD && rx_data == mfp_pkg::CMD_DATA_REQ;
		end
	end

	// ==========================================================
	// Filter decision, ignoring bits 7..9
	logic type_ok;
	logic modes_ok;
	logic addr_ok;
	logic ver_ok;
	assign type_ok  = frame_type <= mfp_pkg::FT_MAX_STD;
	assign modes_ok = dst_mode != mfp_pkg::AM_RSV && src_mode != mfp_pkg::AM_RSV
		&& !(sec_enabled && frame_version == mfp_pkg::VER_2003)
		&& frame_version <= mfp_pkg::VER_2006;
	// No destination: only a beacon, or a frame with a source address, gets through
	assign addr_ok  = mode_present(dst_mode) ? (pan_ok_r && dst_ok_r)
		: (frame_type == mfp_pkg::FT_BEACON || mode_present(src_mode));
	assign addr_match = auto_ack_receive_mode && fields_valid && addr_ok && modes_ok && type_ok;
	// Reserved types bypass the filter only when upload is enabled
	assign frame_accept = auto_ack_receive_mode && fields_valid
		&& (addr_match || (upload_reserved_frame_types && !type_ok));

	always_comb begin
		case (ack_version_filter_select)
			mfp_pkg::AVF_ANY:  ver_ok = 1'b1;
			mfp_pkg::AVF_LE1:  ver_ok = frame_version <= 2'h1;
			mfp_pkg::AVF_LE2:  ver_ok = frame_version <= 2'h2;
			mfp_pkg::AVF_NONE: ver_ok = 1'b0;
			default:           ver_ok = 1'b0;
		endcase
	end

	logic need_ack;
	assign need_ack = addr_match && ack_request && !bcast_r && ver_ok
		&& (frame_type == mfp_pkg::FT_DATA || frame_type == mfp_pkg::FT_CMD);

	// ==========================================================
	// Ack generation: PHR, FCF, sequence, 2 checksum octets
	mfp_pkg::mfp_ack_state_t ack_st_r;
	logic [2:0]  ack_idx_r;
	logic [14:0] dl_r;
	logic [15:0] ack_fcf_r;
	logic [7:0]  ack_seq_r;
	logic [15:0] crc;
	logic        crc_step;

	mfp_crc16 u_crc (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (ack_st_r == mfp_pkg::ACK_WAIT),
		.step    (crc_step),
		.octet   (ack_data),
		.crc     (crc)
	);

	assign ack_valid = ack_st_r == mfp_pkg::ACK_SEND;
	assign ack_last  = ack_valid && ack_idx_r == 3'h5;
	assign crc_step  = ack_valid && ack_ready && ack_idx_r >= 3'h1 && ack_idx_r <= 3'h3;

	always_comb begin
		case (ack_idx_r)
			3'h0:    ack_data = mfp_pkg::ACK_PHR;
			3'h1:    ack_data = ack_fcf_r[7:0];
			3'h2:    ack_data = ack_fcf_r[15:8];
			3'h3:    ack_data = ack_seq_r;
			3'h4:    ack_data = crc[7:0];
			3'h5:    ack_data = crc[15:8];
			default: ack_data = 8'h00;
		endcase
	end

	// Turnaround delay keeps the ack well inside the deadline
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_st_r  <= mfp_pkg::ACK_IDLE;
			ack_idx_r <= 3'h0;
			dl_r      <= 15'h0;
			ack_fcf_r <= mfp_pkg::ACK_FCF_BASE;
			ack_seq_r <= 8'h00;
			ack_late  <= 1'b0;
		end else begin
			case (ack_st_r)
				mfp_pkg::ACK_IDLE: begin
					if (rx_end && rx_fcs_ok && need_ack) begin
						ack_fcf_r <= mfp_pkg::ACK_FCF_BASE
							| {11'h0, data_req_r & ack_pending_flag_value, 4'h0};
						ack_seq_r <= seq_num;
						dl_r      <= 15'h0;
						ack_idx_r <= 3'h0;
						ack_late  <= 1'b0;
						ack_st_r  <= mfp_pkg::ACK_WAIT;
					end
				end
				mfp_pkg::ACK_WAIT: begin
					dl_r <= dl_r + 15'h1;
					if (dl_r == 15'(mfp_pkg::TURN_CYC - 1)) begin
						ack_st_r <= mfp_pkg::ACK_SEND;
					end
				end
				mfp_pkg::ACK_SEND: begin
					dl_r <= dl_r + 15'h1;
					// Deadline overrun is flagged, not hidden, if the transmitter stalls
					if (dl_r == 15'(mfp_pkg::ACK_DEADLINE_CYC - 1)) begin
						ack_late <= 1'b1;
					end
					if (ack_ready) begin
						if (ack_idx_r == 3'h5) begin
							ack_st_r <= mfp_pkg::ACK_DONE;
						end else begin
							ack_idx_r <= ack_idx_r + 3'h1;
						end
					end
				end
				mfp_pkg::ACK_DONE: ack_st_r <= mfp_pkg::ACK_IDLE;
				default:           ack_st_r <= mfp_pkg::ACK_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Auto-retry: wait for ack only if the sent frame asked for one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_wait_ack <= 1'b0;
			tx_finish   <= 1'b0;
		end else begin
			tx_wait_ack <= auto_retry_transmit_mode && tx_done && tx_fcf[mfp_pkg::ACKREQ_BIT];
			tx_finish   <= auto_retry_transmit_mode && tx_done && !tx_fcf[mfp_pkg::ACKREQ_BIT];
		end
	end

endmodule : mfp_frame_parser

// [bench/mfp_chk.sv]
`timescale 1ns/1ns
module mfp_chk (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Configuration
	input  wire logic        auto_retry_transmit_mode,
	input  wire logic        upload_reserved_frame_types,
	// Receive octets
	input  wire logic        rx_start,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	// Transmit side
	input  wire logic        tx_done,
	input  wire logic [15:0] tx_fcf,
	input  wire logic        tx_wait_ack,
	input  wire logic        tx_finish,
	// Parsed fields
	input  wire logic [2:0]  frame_type,
	input  wire logic        sec_enabled,
	input  wire logic        ack_request,
	input  wire logic        intra_pan,
	input  wire logic [1:0]  dst_mode,
	input  wire logic [1:0]  src_mode,
	input  wire logic [1:0]  frame_version,
	input  wire logic [7:0]  seq_num,
	input  wire logic        secured_2006,
	input  wire logic        secured_2003,
	input  wire logic        fields_valid,
	input  wire logic        frame_accept,
	// Ack octets
	input  wire logic        ack_ready,
	input  wire logic        ack_valid,
	input  wire logic [7:0]  ack_data,
	input  wire logic        ack_last,
	input  wire logic        ack_late
);
	// ==========================================================
	// Octet position since frame start, with the two header octets
	logic [1:0] cnt_r;
	logic [7:0] lo_r;
	logic [7:0] hi_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			cnt_r <= 2'h0;
		else if (rx_start)
			cnt_r <= 2'h0;
		else if (rx_valid && cnt_r != 2'h3)
			cnt_r <= cnt_r + 2'h1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lo_r <= 8'h00;
			hi_r <= 8'h00;
		end else if (rx_valid && cnt_r == 2'h0)
			lo_r <= rx_data;
		else if (rx_valid && cnt_r == 2'h1)
			hi_r <= rx_data;
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_tx_wait_req: assert property (tx_done && auto_retry_transmit_mode && tx_fcf[5] |=> tx_wait_ack && !tx_finish)
		else $error("ack wait pulse missing");
	a_tx_finish_now: assert property (tx_done && auto_retry_transmit_mode && !tx_fcf[5] |=> tx_finish && !tx_wait_ack)
		else $error("finish pulse missing");
	a_tx_quiet: assert property (!(tx_done && auto_retry_transmit_mode) |=> !tx_wait_ack && !tx_finish)
		else $error("transmit pulse without cause");
	a_low_fields: assert property (rx_valid && cnt_r == 2'h1 |-> frame_type == lo_r[2:0] && sec_enabled == lo_r[3]
		&& ack_request == lo_r[5] && intra_pan == lo_r[6]) else $error("low control octet misdecoded");
	a_high_fields: assert property (rx_valid && cnt_r == 2'h2 |-> dst_mode == hi_r[3:2] && frame_version == hi_r[5:4]
		&& src_mode == hi_r[7:6]) else $error("high control octet misdecoded");
	a_seq_capture: assert property (rx_valid && cnt_r == 2'h2 |=> seq_num == $past(rx_data) && fields_valid)
		else $error("sequence number not captured");
	a_secured_class: assert property (fields_valid |-> secured_2006 == (sec_enabled && frame_version == 2'h1)
		&& secured_2003 == (sec_enabled && frame_version == 2'h0)) else $error("secured format misclassified");
	a_reserved_type: assert property (fields_valid && frame_type > 3'h3 |-> frame_accept == upload_reserved_frame_types)
		else $error("reserved type acceptance wrong");
	a_ack_hold: assert property (ack_valid && !ack_ready |=> ack_valid && $stable(ack_data))
		else $error("ack octet dropped before taken");
	a_ack_last_end: assert property (ack_valid && ack_ready |=> ack_valid == !$past(ack_last))
		else $error("ack last octet marker wrong");
	a_ack_in_time: assert property (!ack_late)
		else $error("ack deadline missed");
endmodule : mfp_chk

bind mfp_frame_parser mfp_chk u_chk (.sys_clk(sys_clk), .rst(rst), .auto_retry_transmit_mode(auto_retry_transmit_mode),
	.upload_reserved_frame_types(upload_reserved_frame_types), .rx_start(rx_start), .rx_valid(rx_valid),
	.rx_data(rx_data), .tx_done(tx_done), .tx_fcf(tx_fcf), .tx_wait_ack(tx_wait_ack), .tx_finish(tx_finish),
	.frame_type(frame_type), .sec_enabled(sec_enabled), .ack_request(ack_request), .intra_pan(intra_pan),
	.dst_mode(dst_mode), .src_mode(src_mode), .frame_version(frame_version), .seq_num(seq_num),
	.secured_2006(secured_2006), .secured_2003(secured_2003), .fields_valid(fields_valid),
	.frame_accept(frame_accept), .ack_ready(ack_ready), .ack_valid(ack_valid), .ack_data(ack_data), .ack_late(ack_late),
	.ack_last(ack_last));

// [bench/mfp_node.sv]
`timescale 1ns/1ns
module mfp_node (
	// Clock
	input  wire logic       sys_clk,
	// Octets toward the parser
	output logic            rx_start,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_end,
	output logic            rx_fcs_ok,
	// Ack octets from the parser
	input  wire logic       ack_valid,
	input  wire logic [7:0] ack_data,
	output logic            ack_ready
);
	logic [7:0] txq[$];
	logic [7:0] ack_q[$];
	logic       slow;

	initial begin
		rx_start = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		rx_fcs_ok = 1'b0;
		ack_ready = 1'b0;
		slow = 1'b0;
	end

	// A slow taker only accepts every other cycle, so the ack must hold
	always @(posedge sys_clk) begin
		if (ack_valid && ack_ready)
			ack_q.push_back(ack_data);
		ack_ready <= slow ? !ack_ready : 1'b1;
	end

	// Idle data lines show the inverse of the last octet, never a stale copy
	task automatic send(input logic ok);
		@(posedge sys_clk);
		rx_start <= 1'b1;
		@(posedge sys_clk);
		rx_start <= 1'b0;
		foreach (txq[i]) begin
			rx_valid <= 1'b1;
			rx_data <= txq[i];
			@(posedge sys_clk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		rx_end <= 1'b1;
		rx_fcs_ok <= ok;
		@(posedge sys_clk);
		rx_end <= 1'b0;
		rx_fcs_ok <= ~ok;
		@(negedge sys_clk);
		txq.delete();
	endtask : send
endmodule : mfp_node

// [bench/tb_mac_frame_control_parser.sv]
`timescale 1ns/1ns
module tb_mac_frame_control_parser;
	localparam logic [15:0] OWN_PAN   = 16'hc0de;
	localparam logic [15:0] OWN_SHORT = 16'h1234;
	localparam logic [63:0] OWN_EXT   = 64'h0807060504030201;

	logic        sys_clk, rst, auto_ack_receive_mode, auto_retry_transmit_mode;
	logic        upload_reserved_frame_types, ack_pending_flag_value, tx_done;
	logic [1:0]  ack_version_filter_select;
	logic [15:0] tx_fcf;
	logic        rx_start, rx_valid, rx_end, rx_fcs_ok, ack_ready, ack_valid, ack_last, ack_late;
	logic [7:0]  rx_data, seq_num, ack_data;
	logic        tx_wait_ack, tx_finish, sec_enabled, ack_request, intra_pan, secured_2006, secured_2003;
	logic        fields_valid, addr_match, frame_accept;
	logic [2:0]  frame_type;
	logic [1:0]  dst_mode, src_mode, frame_version;
	int          n_mismatch, cmp_count;
	logic [15:0] own_pan, own_short;
	logic [63:0] own_ext;

	mfp_frame_parser dut (.sys_clk(sys_clk), .rst(rst), .auto_ack_receive_mode(auto_ack_receive_mode),
		.auto_retry_transmit_mode(auto_retry_transmit_mode), .upload_reserved_frame_types(upload_reserved_frame_types),
		.ack_pending_flag_value(ack_pending_flag_value), .ack_version_filter_select(ack_version_filter_select),
		.own_pan_id(own_pan), .own_short_addr(own_short), .own_ext_addr(own_ext), .rx_start(rx_start),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .tx_done(tx_done),
		.tx_fcf(tx_fcf), .tx_wait_ack(tx_wait_ack), .tx_finish(tx_finish), .frame_type(frame_type),
		.sec_enabled(sec_enabled), .ack_request(ack_request), .intra_pan(intra_pan), .dst_mode(dst_mode),
		.src_mode(src_mode), .frame_version(frame_version), .seq_num(seq_num), .secured_2006(secured_2006),
		.secured_2003(secured_2003), .fields_valid(fields_valid), .addr_match(addr_match),
		.frame_accept(frame_accept), .ack_ready(ack_ready), .ack_valid(ack_valid), .ack_data(ack_data),
		.ack_last(ack_last), .ack_late(ack_late));

	mfp_node u_node (.sys_clk(sys_clk), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .ack_valid(ack_valid), .ack_data(ack_data), .ack_ready(ack_ready));

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'h0000;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ b[i][k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		return c;
	endfunction : crc16

	task automatic frame(input logic [15:0] f, input logic [7:0] seq, input logic [15:0] dst);
		logic [63:0] a;
		a = f[10] ? OWN_EXT : {48'h0, dst};
		u_node.txq = {f[7:0], f[15:8], seq};
		if (f[11]) begin
			u_node.txq.push_back(OWN_PAN[7:0]);
			u_node.txq.push_back(OWN_PAN[15:8]);
			for (int i = 0; i < (f[10] ? 8 : 2); i++)
				u_node.txq.push_back(a[8*i +: 8]);
		end
		if (f[15]) begin
			if (!f[6])
				repeat (2) u_node.txq.push_back(8'h55);
			for (int i = 0; i < (f[14] ? 8 : 2); i++)
				u_node.txq.push_back(8'h60 + 8'(i));
		end
		if (f[2:0] == mfp_pkg::FT_CMD)
			u_node.txq.push_back(mfp_pkg::CMD_DATA_REQ);
	endtask : frame

	// Ack must be complete within the reply deadline, or absent for 700 cycles
	task automatic expect_ack(input logic [7:0] lo, input logic [7:0] seq, input bit want);
		int          n;
		logic [7:0]  e[$];
		logic [15:0] c;
		n = 0;
		e = {lo, 8'h00, seq};
		c = crc16(e);
		e = {8'h05, e, c[7:0], c[15:8]};
		while (u_node.ack_q.size() < 6 && n < (want ? mfp_pkg::ACK_DEADLINE_CYC : 700)) begin
			@(posedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		chk(u_node.ack_q.size(), want ? 6 : 0, "ack length");
		if (want)
			foreach (e[i])
				chk(u_node.ack_q[i], e[i], "ack octet");
		u_node.ack_q.delete();
	endtask : expect_ack

	// ==========================================================
	// Scenarios
	task automatic t_types;
		for (int u = 0; u < 2; u++)
			for (int t = 0; t < 8; t++) begin
				@(posedge sys_clk);
				upload_reserved_frame_types <= u[0];
				frame({13'h0000, t[2:0]}, 8'(t), 16'h0000);
				u_node.send(1'b1);
				chk(frame_type, t[2:0], "frame type");
				if (t > 3)
					chk(frame_accept, u[0], "reserved type accept");
			end
		$display("types test done");
	endtask : t_types

	task automatic t_fields;
		for (int v = 0; v < 4; v++) begin
			frame({2'(3 - v), 2'(v), 2'(v), 6'h00, 4'h9}, 8'h40 + 8'(v), OWN_SHORT);
			u_node.send(1'b1);
			chk({sec_enabled, frame_version, dst_mode, src_mode}, {1'b1, 2'(v), 2'(v), 2'(3 - v)}, "fields");
			chk({secured_2006, secured_2003}, {v == 1, v == 0}, "secured class");
			chk({fields_valid, seq_num}, {1'b1, 8'h40 + 8'(v)}, "sequence number");
		end
		$display("fields test done");
	endtask : t_fields

	task automatic t_ack;
		frame(16'h9be1, 8'h5a, OWN_SHORT);
		u_node.send(1'b1);
		chk({addr_match, ack_request, intra_pan}, 3'h7, "match and flags");
		expect_ack(8'h02, 8'h5a, 1'b1);
		frame(16'h9c61, 8'h5b, OWN_SHORT);
		u_node.send(1'b1);
		expect_ack(8'h02, 8'h5b, 1'b1);
		@(posedge sys_clk);
		ack_pending_flag_value <= 1'b1;
		own_short <= 16'h4321;
		u_node.slow = 1'b1;
		frame(16'h9863, 8'h11, 16'h4321);
		u_node.send(1'b1);
		expect_ack(8'h12, 8'h11, 1'b1);
		u_node.slow = 1'b0;
		own_short <= OWN_SHORT;
		$display("ack test done");
	endtask : t_ack

	task automatic t_no_ack;
		logic [15:0] f[6] = '{16'h9861, 16'h9841, 16'h9861, 16'ha861, 16'h9861, 16'h9861};
		logic [15:0] d[6] = '{16'h4321, OWN_SHORT, 16'hffff, OWN_SHORT, OWN_SHORT, OWN_SHORT};
		logic [1:0]  a[6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0};
		logic        m[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			ack_version_filter_select <= a[i];
			auto_ack_receive_mode <= m[i];
			frame(f[i], 8'(i), d[i]);
			u_node.send(1'b1);
			expect_ack(8'h00, 8'h00, 1'b0);
		end
		chk(addr_match, 1'b0, "no filtering outside auto ack");
		@(posedge sys_clk);
		auto_ack_receive_mode <= 1'b1;
		ack_version_filter_select <= mfp_pkg::AVF_ANY;
		$display("no ack test done");
	endtask : t_no_ack

	task automatic t_tx;
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			auto_retry_transmit_mode <= k[1];
			tx_fcf <= {10'h261, k[0], 5'h01};
			tx_done <= 1'b1;
			@(posedge sys_clk);
			tx_done <= 1'b0;
			@(negedge sys_clk);
			chk({tx_wait_ack, tx_finish}, {k[1] & k[0], k[1] & !k[0]}, "transmit end");
		end
		$display("transmit test done");
	endtask : t_tx

	task automatic complete_run;
		$display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (50000) @(posedge sys_clk);
		n_mismatch++;
		complete_run();
	end

	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		rst = 1'b1;
		auto_ack_receive_mode = 1'b1;
		auto_retry_transmit_mode = 1'b0;
		upload_reserved_frame_types = 1'b0;
		ack_pending_flag_value = 1'b0;
		ack_version_filter_select = 2'h0;
		tx_done = 1'b0;
		tx_fcf = 16'h0000;
		own_pan = OWN_PAN;
		own_short = OWN_SHORT;
		own_ext = OWN_EXT;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		t_types();
		t_fields();
		t_ack();
		t_no_ack();
		t_tx();
		complete_run();
	end
endmodule : tb_mac_frame_control_parser
